/* hw/bkt_caldiv.sv */
// divide-by-64 of the rtc clock level for the calibration output
// assumes rtc_lvl_i is already synchronised and far slower than clk_i
`timescale 1ns/1ps
`include "bkt_map.svh"
module bkt_caldiv (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// rtc clock level and divided output
	input wire logic rtc_lvl_i,
	output logic div_o
);
	typedef struct packed {
		logic last;
		logic [4:0] cnt;
		logic out;
	} bkt_caldiv_s;
	bkt_caldiv_s state_reg;
	bkt_caldiv_s state_next;

	// toggle the output every 32 rising rtc edges
	always_comb begin
		state_next = state_reg;
		state_next.last = rtc_lvl_i;
		if (rtc_lvl_i && !state_reg.last) begin
			state_next.cnt = state_reg.cnt + 5'h01;
			if (state_reg.cnt == `BKT_CAL_DIV_HALF) begin
				state_next.out = !state_reg.out;
			end
		end
		if (srst_i) begin
			state_next = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		state_reg <= state_next;
	end

	assign div_o = state_reg.out;
endmodule

/* hw/bkt_map.svh */
// register offsets, field positions and reset values of the backup-domain register block
// assumes byte addressing with one 16-bit register per aligned 32-bit word
`ifndef BKT_MAP_SVH
`define BKT_MAP_SVH
`define BKT_DATA_LO_FIRST 8'h04
`define BKT_DATA_LO_LAST 8'h28
`define BKT_DATA_HI_FIRST 8'h40
`define BKT_DATA_HI_LAST 8'hBC
`define BKT_OFF_OCTL 8'h2C
`define BKT_OFF_TPCTL 8'h30
`define BKT_OFF_TPCS 8'h34
`define BKT_OFF_WEN 8'hC0
`define BKT_OFF_IRQ_STAT 8'hC4
`define BKT_OFF_IRQ_EN 8'hC8
`define BKT_OFF_IRQ_CLR 8'hCC
`define BKT_DATA_WORDS 42
`define BKT_DATA_LO_WORDS 10
`define BKT_OCTL_CAL_LSB 0
`define BKT_OCTL_CAL_CLOCK_OUT_ENABLE 7
`define BKT_OCTL_RTC_PULSE_OUT_ENABLE 8
`define BKT_OCTL_RTC_OUT_SELECT 9
`define BKT_TPCTL_EN 0
`define BKT_TPCTL_AL 1
`define BKT_TPCS_TER 0
`define BKT_TPCS_TIR 1
`define BKT_TPCS_TAMPER_IRQ_ENABLE 2
`define BKT_TPCS_TEF 8
`define BKT_TPCS_TIF 9
`define BKT_CAL_DIV_HALF 5'h1F
`define BKT_RESET_WORD 16'h0000
`endif

/* hw/bkt_pkg.sv */
// types shared by the backup-domain register block
// assumes bkt_map.svh supplies the numeric constants
package bkt_pkg;
	typedef logic [7:0] bkt_addr_t;
	typedef logic [15:0] bkt_word_t;
endpackage

/* hw/bkt_regs.sv */
// backup-domain register block: data words, rtc output control, tamper detection
// assumes a plain strobe bus on clk_i; pins and rtc signals are asynchronous
// Overview of operation
// - writes to the block other than the write enable register are ignored until the write enable is set
// - forty-two 16-bit data words survive standby, system and power reset
// - data words sit at 0x04..0x28 and 0x40..0xBC, four bytes apart
// - calibration output enable drives tamper pin with rtc clock divided by 64
// - pulse output enable overrides the calibration output on the tamper pin
// - output select picks alarm pulse at 0, second pulse at 1
// - 7-bit calibration value counts pulses dropped or added per 2^20
// - output control except bit 7 clears on backup reset; bit 7 clears on power reset
// - active level bit 0 means pin active high, 1 active low
// - enabled detection owns the pin and active level clears data words
// - edge detection is gated by the enable; set level before enable
// - pin already active when enabled still gives one tamper event
// - event flag bit 8 set by tamper, cleared by writing bit 0
// - interrupt flag bit 9 clears by bit 1 write or enable low
// - interrupt enable and status register clear on system reset and wake-up
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "bkt_map.svh"
module bkt_regs (
	// clock and resets
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic bkp_rst_i,
	input wire logic power_on_off_reset_i,
	input wire logic standby_wake_i,
	// register bus
	input wire bkt_pkg::bkt_addr_t addr_i,
	input wire bkt_pkg::bkt_word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output bkt_pkg::bkt_word_t rdata_o,
	// rtc sources
	input wire logic rtc_clk_i,
	input wire logic rtc_alarm_i,
	input wire logic rtc_second_i,
	// tamper pin
	input wire logic tamper_pin_i,
	output logic tamper_pin_o,
	output logic tamper_pin_oe_o,
	// interrupt
	output logic irq_o
);
	import bkt_pkg::*;

	typedef struct packed {
		logic [`BKT_DATA_WORDS-1:0][15:0] data;
		logic [6:0] cal;
		logic cal_clock_out_enable;
		logic rtc_pulse_out_enable;
		logic rtc_out_select;
		logic tp_en;
		logic tp_al;
		logic tamper_irq_enable;
		logic tamper_event_flag;
		logic tamper_irq_flag;
		logic wen;
		logic [1:0] ist;
		logic [1:0] ien;
		logic act_last;
		bkt_word_t rdata;
		logic pin_o;
		logic pin_oe;
		logic irq;
	} bkt_regs_s;

	bkt_regs_s state_reg;
	bkt_regs_s state_next;
	logic tamper_sync;
	logic rtc_sync;
	logic alarm_sync;
	logic second_sync;
	logic cal_div;
	logic tamper_act;
	logic tamper_event;

	// map a byte address to a data word index, or -1 if not a data word
	function automatic int data_index(input bkt_addr_t a);
		if (a[1:0] != 2'b00) begin
			return -1;
		end
		if (a >= `BKT_DATA_LO_FIRST && a <= `BKT_DATA_LO_LAST) begin
			return int'(a[7:2]) - 1;
		end
		if (a >= `BKT_DATA_HI_FIRST && a <= `BKT_DATA_HI_LAST) begin
			return int'(a[7:2]) - 16 + `BKT_DATA_LO_WORDS;
		end
		return -1;
	endfunction

	// pin and rtc inputs cross into clk_i
	bkt_sync u_sync_tamper (.clk_i(clk_i), .srst_i(srst_i), .async_i(tamper_pin_i), .sync_o(tamper_sync));
	bkt_sync u_sync_rtc (.clk_i(clk_i), .srst_i(srst_i), .async_i(rtc_clk_i), .sync_o(rtc_sync));
	bkt_sync u_sync_alarm (.clk_i(clk_i), .srst_i(srst_i), .async_i(rtc_alarm_i), .sync_o(alarm_sync));
	bkt_sync u_sync_second (.clk_i(clk_i), .srst_i(srst_i), .async_i(rtc_second_i), .sync_o(second_sync));

	// rtc clock divided by 64 for the calibration output
	bkt_caldiv u_caldiv (.clk_i(clk_i), .srst_i(bkp_rst_i), .rtc_lvl_i(rtc_sync), .div_o(cal_div));

	// active level and gated edge detection; last level starts low on enable
	assign tamper_act = tamper_sync ^ state_reg.tp_al;
	assign tamper_event = state_reg.tp_en && tamper_act && !state_reg.act_last;

	// next-state logic for the whole block
	always_comb begin
		int idx;
		logic wok;
		idx = data_index(addr_i);
		wok = wr_i && state_reg.wen;
		state_next = state_reg;
		state_next.act_last = state_reg.tp_en ? tamper_act : 1'b0;
		state_next.rdata = '0;
		// write enable register is always writable so software can open the gate
		if (wr_i && addr_i == `BKT_OFF_WEN) begin
			state_next.wen = wdata_i[0];
		end
		if (wok && idx >= 0) begin
			state_next.data[idx] = wdata_i;
		end
		if (wok && addr_i == `BKT_OFF_OCTL) begin
			state_next.cal = wdata_i[`BKT_OCTL_CAL_LSB +: 7];
			state_next.cal_clock_out_enable = wdata_i[`BKT_OCTL_CAL_CLOCK_OUT_ENABLE];
			state_next.rtc_pulse_out_enable = wdata_i[`BKT_OCTL_RTC_PULSE_OUT_ENABLE];
			state_next.rtc_out_select = wdata_i[`BKT_OCTL_RTC_OUT_SELECT];
		end
		if (wok && addr_i == `BKT_OFF_TPCTL) begin
			state_next.tp_en = wdata_i[`BKT_TPCTL_EN];
			state_next.tp_al = wdata_i[`BKT_TPCTL_AL];
		end
		if (wok && addr_i == `BKT_OFF_TPCS) begin
			state_next.tamper_irq_enable = wdata_i[`BKT_TPCS_TAMPER_IRQ_ENABLE];
			if (wdata_i[`BKT_TPCS_TER]) begin
				state_next.tamper_event_flag = 1'b0;
			end
			if (wdata_i[`BKT_TPCS_TIR]) begin
				state_next.tamper_irq_flag = 1'b0;
			end
		end
		if (wok && addr_i == `BKT_OFF_IRQ_EN) begin
			state_next.ien = wdata_i[1:0];
		end
		if (wok && addr_i == `BKT_OFF_IRQ_CLR) begin
			state_next.ist = state_reg.ist & ~wdata_i[1:0];
		end
		if (!state_next.tamper_irq_enable) begin
			state_next.tamper_irq_flag = 1'b0;
		end
		// tamper event: set wins over clear, wipe data words
		if (tamper_event) begin
			state_next.tamper_event_flag = 1'b1;
			state_next.ist[0] = 1'b1;
			// an enable written low in this cycle keeps the interrupt flag clear
			if (state_next.tamper_irq_enable) begin
				state_next.tamper_irq_flag = 1'b1;
				state_next.ist[1] = 1'b1;
			end
		end
		if (state_reg.tp_en && tamper_act) begin
			state_next.data = '0;
		end
		// read data, one cycle after the strobe
		if (rd_i) begin
			if (idx >= 0) begin
				state_next.rdata = state_reg.data[idx];
			end else begin
				unique case (addr_i)
					`BKT_OFF_OCTL: state_next.rdata = {6'h00, state_reg.rtc_out_select, state_reg.rtc_pulse_out_enable,
						state_reg.cal_clock_out_enable, state_reg.cal};
					`BKT_OFF_TPCTL: state_next.rdata = {14'h0000, state_reg.tp_al, state_reg.tp_en};
					`BKT_OFF_TPCS: state_next.rdata = {6'h00, state_reg.tamper_irq_flag, state_reg.tamper_event_flag, 5'h00,
						state_reg.tamper_irq_enable, 2'b00};
					`BKT_OFF_WEN: state_next.rdata = {15'h0000, state_reg.wen};
					`BKT_OFF_IRQ_STAT: state_next.rdata = {14'h0000, state_reg.ist};
					`BKT_OFF_IRQ_EN: state_next.rdata = {14'h0000, state_reg.ien};
					default: state_next.rdata = `BKT_RESET_WORD;
				endcase
			end
		end
		// tamper pin output mux; detection owns the pin when enabled
		state_next.pin_oe = !state_next.tp_en && (state_next.rtc_pulse_out_enable || state_next.cal_clock_out_enable);
		if (state_next.rtc_pulse_out_enable) begin
			state_next.pin_o = state_next.rtc_out_select ? second_sync : alarm_sync;
		end else begin
			state_next.pin_o = state_next.cal_clock_out_enable && cal_div;
		end
		state_next.irq = |(state_next.ist & state_next.ien) || state_next.tamper_irq_flag;
		// resets by domain; data words are kept on all but the backup reset
		if (srst_i || standby_wake_i) begin
			state_next.tamper_irq_enable = 1'b0;
			state_next.tamper_event_flag = 1'b0;
			state_next.tamper_irq_flag = 1'b0;
			state_next.wen = 1'b0;
			state_next.ist = '0;
			state_next.ien = '0;
			state_next.rdata = '0;
			state_next.irq = 1'b0;
			state_next.act_last = 1'b0;
		end
		if (power_on_off_reset_i) begin
			state_next.cal_clock_out_enable = 1'b0;
		end
		if (bkp_rst_i) begin
			state_next.data = '0;
			state_next.cal = '0;
			state_next.rtc_pulse_out_enable = 1'b0;
			state_next.rtc_out_select = 1'b0;
			state_next.tp_en = 1'b0;
			state_next.tp_al = 1'b0;
			state_next.pin_o = 1'b0;
			state_next.pin_oe = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		state_reg <= state_next;
	end

	assign rdata_o = state_reg.rdata;
	assign tamper_pin_o = state_reg.pin_o;
	assign tamper_pin_oe_o = state_reg.pin_oe;
	assign irq_o = state_reg.irq;

	// checks on the block's own behaviour
	AST_WRITE_GATED: assert property (@(posedge clk_i) disable iff (srst_i || bkp_rst_i)
		wr_i && !state_reg.wen && addr_i == `BKT_OFF_TPCTL |=> $stable(state_reg.tp_en))
		else $error("write taken while write enable low");
	AST_EVENT_SETS_FLAG: assert property (@(posedge clk_i) disable iff (srst_i || standby_wake_i)
		tamper_event |=> state_reg.tamper_event_flag)
		else $error("tamper event did not set event flag");
	AST_TIF_NEEDS_IE: assert property (@(posedge clk_i) disable iff (srst_i)
		!state_reg.tamper_irq_enable |-> !state_reg.tamper_irq_flag)
		else $error("interrupt flag set with enable low");
	AST_IRQ_FOLLOWS_TIF: assert property (@(posedge clk_i) disable iff (srst_i)
		state_reg.tamper_irq_flag |-> irq_o)
		else $error("interrupt request missing while flag set");
	AST_DATA_WIPE: assert property (@(posedge clk_i) disable iff (srst_i || bkp_rst_i)
		state_reg.tp_en && tamper_act |=> state_reg.data == '0)
		else $error("data words kept after active tamper level");
	AST_ONE_EVENT: assert property (@(posedge clk_i) disable iff (srst_i)
		tamper_event |=> !tamper_event)
		else $error("two tamper events back to back");
	AST_RTC_PULSE_OUT_ENABLE_PRIO: assert property (@(posedge clk_i) disable iff (srst_i || bkp_rst_i)
		state_reg.rtc_pulse_out_enable && !state_reg.tp_en |-> tamper_pin_oe_o)
		else $error("pulse output not driven");
	AST_TPCS_RD: assert property (@(posedge clk_i) disable iff (srst_i)
		rd_i && addr_i == `BKT_OFF_TPCS |=> rdata_o[1:0] == 2'b00)
		else $error("clear bits read nonzero");
	AST_IE_RESET: assert property (@(posedge clk_i) srst_i |=> !state_reg.tamper_irq_enable)
		else $error("interrupt enable survived system reset");
	AST_PRESENT_ON_ENABLE: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(state_reg.tp_en) && tamper_act |-> tamper_event)
		else $error("already active pin gave no event");
	AST_TP_OWNS_PIN: assert property (@(posedge clk_i) disable iff (srst_i)
		state_reg.tp_en |-> !tamper_pin_oe_o)
		else $error("pin driven while tamper detection enabled");
	AST_WEN_RESET: assert property (@(posedge clk_i) srst_i || standby_wake_i |=> !state_reg.wen)
		else $error("write enable survived reset");
	AST_CAL_CLOCK_OUT_ENABLE_POR: assert property (@(posedge clk_i) power_on_off_reset_i |=> !state_reg.cal_clock_out_enable)
		else $error("calibration output enable survived power reset");
	COV_TAMPER: cover property (@(posedge clk_i) tamper_event);
	COV_IRQ: cover property (@(posedge clk_i) $rose(irq_o));
	COV_PULSE_OUT: cover property (@(posedge clk_i) state_reg.rtc_pulse_out_enable && tamper_pin_oe_o);
	COV_CAL_OUT: cover property (@(posedge clk_i) state_reg.cal_clock_out_enable && !state_reg.rtc_pulse_out_enable && tamper_pin_o);
	COV_WIPE: cover property (@(posedge clk_i) state_reg.tp_en && tamper_act && |state_reg.data);
endmodule

/* hw/bkt_sync.sv */
// two flip-flop synchroniser for one level from outside the clock domain
// assumes the input may change at any time relative to clk_i
`timescale 1ns/1ps
module bkt_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// level in and out
	input wire logic async_i,
	output logic sync_o
);
	typedef struct packed {
		logic first;
		logic second;
	} bkt_sync_s;
	bkt_sync_s state_reg;
	bkt_sync_s state_next;

	// shift the level through two stages
	always_comb begin
		state_next.first = async_i;
		state_next.second = state_reg.first;
		if (srst_i) begin
			state_next = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		state_reg <= state_next;
	end

	assign sync_o = state_reg.second;
endmodule

/* testbench/testbench.sv */
// testbench for the backup-domain register block
// assumes the design files under hw/ are compiled first
`timescale 1ns/1ps
`include "bkt_map.svh"
module testbench;
	import bkt_pkg::*;
	logic clk_i, srst_i, bkp_rst_i, power_on_off_reset_i, standby_wake_i;
	logic wr_i, rd_i, rtc_clk_i, rtc_alarm_i, rtc_second_i;
	logic tamper_pin_i, tamper_pin_o, tamper_pin_oe_o, irq_o;
	bkt_addr_t addr_i;
	bkt_word_t wdata_i, rdata_o, rv;
	int n_mismatch = 0;
	int checks = 0;
	int cycles = 0;

	// block under test
	bkt_regs bkt_regs_inst (.clk_i(clk_i), .srst_i(srst_i), .bkp_rst_i(bkp_rst_i),
		.power_on_off_reset_i(power_on_off_reset_i), .standby_wake_i(standby_wake_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.rtc_clk_i(rtc_clk_i), .rtc_alarm_i(rtc_alarm_i), .rtc_second_i(rtc_second_i),
		.tamper_pin_i(tamper_pin_i), .tamper_pin_o(tamper_pin_o),
		.tamper_pin_oe_o(tamper_pin_oe_o), .irq_o(irq_o));

	// 250 MHz clock
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	// hang guard, the whole run needs under 4000 cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// word and bit comparisons
	task automatic chk(input string what, input bkt_word_t exp, input bkt_word_t got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	// one-cycle bus write and read
	task automatic wr(input bkt_addr_t a, input bkt_word_t d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask
	task automatic rchk(input string what, input bkt_addr_t a, input bkt_word_t exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1;
		chk(what, exp, rdata_o);
	endtask

	// one-cycle pulse: 0 system, 1 backup, 2 power, 3 standby wake
	task automatic pulse(input int k);
		@(posedge clk_i);
		case (k)
			0: srst_i <= 1'h1;
			1: bkp_rst_i <= 1'h1;
			2: power_on_off_reset_i <= 1'h1;
			default: standby_wake_i <= 1'h1;
		endcase
		@(posedge clk_i);
		{srst_i, bkp_rst_i, power_on_off_reset_i, standby_wake_i} <= 4'h0;
	endtask

	// waits a bounded time for the interrupt level
	task automatic wait_irq(input logic exp);
		#1;
		for (int i = 0; i < 20; i++) begin
			if (irq_o === exp) break;
			@(posedge clk_i);
			#1;
		end
		chk_bit("irq_o", exp, irq_o);
	endtask

	// sets the tamper pin and lets synchroniser and flags settle
	task automatic set_pin(input logic v);
		@(posedge clk_i);
		tamper_pin_i <= v;
		repeat (8) @(posedge clk_i);
	endtask

	// writes or checks all data words, value made from the offset
	task automatic data_all(input logic wrt);
		bkt_addr_t a;
		for (int i = 0; i < `BKT_DATA_WORDS; i++) begin
			a = (i < `BKT_DATA_LO_WORDS) ? 8'(4 + 4 * i) : 8'(`BKT_DATA_HI_FIRST + 4 * (i - 10));
			if (wrt) wr(a, {8'hC3, a});
			else rchk("data", a, {8'hC3, a});
		end
	endtask

	// reset values and the write lock
	task automatic t_lock();
		rchk("octl", `BKT_OFF_OCTL, 16'h0000);
		rchk("tpcs", `BKT_OFF_TPCS, 16'h0000);
		wr(8'h04, 16'hA5A5);
		rchk("locked", 8'h04, 16'h0000);
		wr(`BKT_OFF_TPCTL, 16'h0003);
		rchk("tpctl locked", `BKT_OFF_TPCTL, 16'h0000);
		wr(`BKT_OFF_WEN, 16'h0001);
		wr(8'h04, 16'hA5A5);
		rchk("open", 8'h04, 16'hA5A5);
		wr(`BKT_OFF_WEN, 16'h0000);
		wr(8'h04, 16'h5A5A);
		rchk("relocked", 8'h04, 16'hA5A5);
	endtask

	// data map, retention over resets
	task automatic t_data();
		wr(`BKT_OFF_WEN, 16'h0001);
		data_all(1'h1);
		data_all(1'h0);
		rchk("hole", 8'h3C, 16'h0000);
		pulse(0);
		pulse(2);
		pulse(3);
		data_all(1'h0);
		wr(8'h04, 16'h0000);
		rchk("srst lock", 8'h04, 16'hC304);
	endtask

	// drives the rtc pulses and checks the pin drive
	task automatic pin_out(input logic al, input logic sec, input logic exp);
		@(posedge clk_i);
		rtc_alarm_i <= al;
		rtc_second_i <= sec;
		repeat (6) @(posedge clk_i);
		#1;
		chk_bit("pin_oe", 1'h1, tamper_pin_oe_o);
		chk_bit("pin", exp, tamper_pin_o);
	endtask

	// pulse output select, priority and reset domains of output control
	task automatic t_octl();
		wr(`BKT_OFF_WEN, 16'h0001);
		wr(`BKT_OFF_OCTL, 16'h03FF);
		rchk("octl", `BKT_OFF_OCTL, 16'h03FF);
		pin_out(1'h0, 1'h1, 1'h1);
		pin_out(1'h1, 1'h0, 1'h0);
		wr(`BKT_OFF_OCTL, 16'h01FF);
		pin_out(1'h1, 1'h0, 1'h1);
		pin_out(1'h0, 1'h1, 1'h0);
		pulse(1);
		rchk("octl bkp", `BKT_OFF_OCTL, 16'h0080);
		pulse(2);
		rchk("octl por", `BKT_OFF_OCTL, 16'h0000);
	endtask

	// calibration clock: 256 rtc periods give 8 pin changes
	task automatic t_cal();
		int n;
		logic last;
		wr(`BKT_OFF_WEN, 16'h0001);
		wr(`BKT_OFF_OCTL, 16'h0080);
		repeat (6) @(posedge clk_i);
		n = 0;
		last = tamper_pin_o;
		for (int i = 0; i < 2060; i++) begin
			@(posedge clk_i);
			if (i % 4 == 0 && i < 2048) rtc_clk_i <= ~rtc_clk_i;
			#1;
			if (tamper_pin_o !== last) n++;
			last = tamper_pin_o;
		end
		chk("cal edges", 16'h0008, 16'(n));
	endtask

	// tamper detection, flags, interrupt and their clears
	task automatic t_tamper();
		wr(`BKT_OFF_OCTL, 16'h0000);
		wr(`BKT_OFF_TPCS, 16'h0004);
		wr(8'h08, 16'h1111);
		set_pin(1'h1);
		rchk("off", `BKT_OFF_TPCS, 16'h0004);
		rchk("kept", 8'h08, 16'h1111);
		wr(`BKT_OFF_TPCTL, 16'h0001);
		wait_irq(1'h1);
		rchk("event", `BKT_OFF_TPCS, 16'h0304);
		rchk("wiped", 8'h08, 16'h0000);
		wr(`BKT_OFF_TPCS, 16'h0005);
		set_pin(1'h1);
		rchk("ter", `BKT_OFF_TPCS, 16'h0204);
		wr(`BKT_OFF_TPCS, 16'h0006);
		rchk("tir", `BKT_OFF_TPCS, 16'h0004);
		wait_irq(1'h0);
		set_pin(1'h0);
		wr(`BKT_OFF_TPCTL, 16'h0002);
		set_pin(1'h1);
		wr(`BKT_OFF_TPCTL, 16'h0003);
		wr(8'h08, 16'h2222);
		set_pin(1'h1);
		rchk("idle", `BKT_OFF_TPCS, 16'h0004);
		set_pin(1'h0);
		wait_irq(1'h1);
		rchk("wiped low", 8'h08, 16'h0000);
		wr(`BKT_OFF_TPCS, 16'h0000);
		rchk("tamper_irq_enable off", `BKT_OFF_TPCS, 16'h0100);
		wait_irq(1'h0);
		set_pin(1'h1);
		wr(`BKT_OFF_TPCTL, 16'h0000);
		rchk("ist", `BKT_OFF_IRQ_STAT, 16'h0003);
		wr(`BKT_OFF_IRQ_EN, 16'h0001);
		wait_irq(1'h1);
		wr(`BKT_OFF_IRQ_EN, 16'h0000);
		wait_irq(1'h0);
		wr(`BKT_OFF_IRQ_CLR, 16'h0003);
		rchk("ist clr", `BKT_OFF_IRQ_STAT, 16'h0000);
		wr(`BKT_OFF_TPCS, 16'h0004);
		pulse(3);
		rchk("wake", `BKT_OFF_TPCS, 16'h0000);
		wr(`BKT_OFF_WEN, 16'h0001);
		wr(`BKT_OFF_TPCS, 16'h0004);
		pulse(0);
		rchk("srst", `BKT_OFF_TPCS, 16'h0000);
	endtask

	// main sequence
	initial begin
		{srst_i, bkp_rst_i, power_on_off_reset_i} = 3'h7;
		{standby_wake_i, wr_i, rd_i, rtc_clk_i} = 4'h0;
		{rtc_alarm_i, rtc_second_i, tamper_pin_i} = 3'h0;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		repeat (2) @(posedge clk_i);
		{srst_i, bkp_rst_i, power_on_off_reset_i} <= 3'h0;
		t_lock();
		t_data();
		t_octl();
		t_cal();
		t_tamper();
		report_and_stop();
	end
endmodule
